// *** hw/upam_pkg.sv ***
package upam_pkg;
    // ==========================================================
    // page geometry
    localparam int PAGE_AW = 12;              // 4-kbyte page, byte offsets
    localparam int WORD_W = 16;               // every register is one word
    localparam int WORD_AW = PAGE_AW - 1;     // word index width
    localparam int PAGE_WORDS = 2048;         // 4096 bytes / 2
    // ==========================================================
    // region bounds, byte offsets (inclusive)
    localparam logic [11:0] BUSIF_LO = 12'h000;
    localparam logic [11:0] BUSIF_HI = 12'h045;
    localparam logic [11:0] STCTL_LO = 12'h100;
    localparam logic [11:0] STCTL_HI = 12'h13f;
    localparam logic [11:0] TXINI_LO = 12'h140;
    localparam logic [11:0] TXINI_HI = 12'h14f;
    localparam logic [11:0] AFILT_LO = 12'h150;
    localparam logic [11:0] AFILT_HI = 12'h15d;
    localparam logic [11:0] RXWIN_LO = 12'h400;
    localparam logic [11:0] RXWIN_HI = 12'h9ff;
    localparam logic [11:0] TXWIN_LO = 12'ha00;
    localparam logic [11:0] TXWIN_HI = 12'hfff;
    // ==========================================================
    // named registers
    localparam logic [11:0] TRANSMIT_COMMAND_REG_OFS = 12'h144;
    localparam logic [11:0] TXLEN_OFS = 12'h146;
    localparam logic [11:0] DMA_SOF_OFS = 12'h026;
    localparam logic [11:0] DMA_CNT_OFS = 12'h028;
    localparam logic [11:0] DMA_BYTES_OFS = 12'h02a;
    // ==========================================================
    // reset values
    localparam logic MEM_MODE_RST = 1'b0;     // i/o mode after reset
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] UNDEF_RD = 16'h0000; // reserved read value

    // decoded region, one-hot
    typedef enum logic [6:0] {
        UPAM_RG_RSVD  = 7'b0000001,
        UPAM_RG_BUSIF = 7'b0000010,
        UPAM_RG_STCTL = 7'b0000100,
        UPAM_RG_TXINI = 7'b0001000,
        UPAM_RG_AFILT = 7'b0010000,
        UPAM_RG_RXWIN = 7'b0100000,
        UPAM_RG_TXWIN = 7'b1000000
    } upam_region_e;

    // host access path
    typedef enum logic [1:0] {
        UPAM_PATH_IO  = 2'b01,
        UPAM_PATH_MEM = 2'b10
    } upam_path_e;

    // sorts a byte offset into its region
    function automatic upam_region_e upam_decode(input logic [11:0] ofs);
        upam_region_e r;
        r = UPAM_RG_RSVD;
        if (ofs <= BUSIF_HI) begin
            r = UPAM_RG_BUSIF;
        end else if (ofs >= STCTL_LO && ofs <= STCTL_HI) begin
            r = UPAM_RG_STCTL;
        end else if (ofs >= TXINI_LO && ofs <= TXINI_HI) begin
            r = UPAM_RG_TXINI;
        end else if (ofs >= AFILT_LO && ofs <= AFILT_HI) begin
            r = UPAM_RG_AFILT;
        end else if (ofs >= RXWIN_LO && ofs <= RXWIN_HI) begin
            r = UPAM_RG_RXWIN;
        end else if (ofs >= TXWIN_LO) begin
            r = UPAM_RG_TXWIN;
        end
        return r;
    endfunction : upam_decode
endpackage : upam_pkg

// *** hw/upam_if.sv ***
`timescale 1ns/1ns
// ==========================================================
// host-to-page link: one word access per request
interface upam_if;
    import upam_pkg::*;
    logic req;                 // access request, held until ack
    logic wr;                  // 1 write, 0 read
    logic mem_path;            // 1 memory-space cycle, 0 i/o-space cycle
    logic [11:0] ofs;          // byte offset in page, even
    logic [15:0] wdata;        // write word
    logic ack;                 // one-cycle completion
    logic [15:0] rdata;        // read word, valid with ack
    logic err;                 // access refused (wrong path/odd/asleep)

    modport dev (
        input req, wr, mem_path, ofs, wdata,
        output ack, rdata, err
    );
    modport host (
        output req, wr, mem_path, ofs, wdata,
        input ack, rdata, err
    );
endinterface : upam_if

// *** hw/upam_dev.sv ***
`timescale 1ns/1ns
// ==========================================================
// page decoder and store
// one host port, one word per request, answered a cycle later;
// one request per answer keeps the decode a single cycle deep
// the page ram has no reset: a word read before it is written
// gives whatever the ram powered up with
// the transmit window and the initiate words are write-only: reads
// there return zero, like reserved space
module upam_dev
    import upam_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    upam_if.dev bus,
    // ==== user side ====
    input wire logic mem_mode_en_i,      // engine allows memory path
    input wire logic suspend_i,          // engine enters suspend
    output logic suspended_o,            // device in software suspend
    output logic wake_o,                 // one-cycle wake request
    output logic mem_mode_o,             // memory path active
    input wire logic dma_active_i,       // dma transfer running
    input wire logic [15:0] dma_sof_i,   // dma start of frame
    input wire logic [15:0] dma_cnt_i,   // dma frame count
    input wire logic [15:0] dma_bytes_i, // dma byte count
    output logic tx_start_o,             // one-cycle transmit request
    output logic [15:0] tx_cmd_o,        // latched transmit command
    output logic [15:0] tx_len_o,        // latched transmit length
    output logic [6:0] region_o          // region of last access
);
    // ==========================================================
    // page storage
    // frames and registers share one array, as they share the page;
    // splitting it would save ports but double the decode
    logic [15:0] page_mem [PAGE_WORDS]; // shared frame/register ram
    // ==========================================================
    // state registers, each owned by one process below
    logic mem_mode_reg;                  // access path state
    logic suspended_reg; // asleep until an i/o write
    logic cmd_seen_reg;                  // command written, length pending
    logic [15:0] rdata_reg; // read word, zero between answers
    logic ack_reg; // answer pulse
    logic err_reg; // refusal flag, only with the answer
    logic [6:0] region_reg; // region of the last taken access
    logic [15:0] tx_cmd_reg; // latched transmit command
    logic [15:0] tx_len_reg; // latched transmit length
    logic tx_start_reg; // transmit request pulse
    logic wake_reg; // wake pulse

    // ==========================================================
    // decode of the request standing on the link this cycle
    upam_region_e rg;                    // current decode
    logic [WORD_AW-1:0] widx;            // word index
    logic path_ok;                       // request uses configured path
    logic take;                          // access accepted this cycle
    logic writable;                      // region accepts host writes

    // region lookup is purely from the offset; path and mode only
    // gate acceptance, never which region is hit
    assign rg = upam_decode(bus.ofs);
    // byte offset to word index: bit 0 never addresses the ram
    assign widx = bus.ofs[PAGE_AW-1:1];
    // i/o cycles always reach the page so a sleeping driver can wake it
    assign path_ok = bus.mem_path ? mem_mode_reg : 1'b1;
    // odd byte offsets are not words; refuse them
    // the !ack_reg term keeps a held request from being taken twice;
    // a suspended device takes nothing, the wake write included
    assign take = bus.req && !ack_reg && path_ok && !bus.ofs[0]
                  && !suspended_reg;
    // read-only frame window and reserved space drop writes
    // a stray host write there could spoil a frame being received
    assign writable = (rg != UPAM_RG_RSVD) && (rg != UPAM_RG_RXWIN);

    // ==========================================================
    // access path mode
    // the engine owns this switch; the host cannot flip it through
    // the link, so a memory cycle seen while it is low is refused
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mem_mode_reg <= MEM_MODE_RST;
        end else begin
            mem_mode_reg <= mem_mode_en_i; // enabled later by setup
        end
    end

    // ==========================================================
    // suspend and wake
    // only an i/o-space write wakes: the memory window may not be
    // mapped at all while the device sleeps
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            suspended_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= 1'b0;
            // suspend outranks a wake in the same cycle; while the
            // engine holds suspend high the page stays asleep
            if (suspend_i) begin
                suspended_reg <= 1'b1;
            end else if (suspended_reg && bus.req && bus.wr
                && !bus.mem_path && !ack_reg) begin
                suspended_reg <= 1'b0; // i/o write is the wake
                wake_reg <= 1'b1; // one pulse per wake
            end
        end
    end

    // ==========================================================
    // handshake and read data
    // every request is answered exactly one cycle after it stands,
    // refused or not, so the host never waits on a lost request
    // ack and err are registered, so the host samples them clean
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= WORD_RST;
            region_reg <= UPAM_RG_RSVD;
        end else begin
            ack_reg <= bus.req && !ack_reg; // one ack per request
            // refusal rides on the answer: wrong path, odd or asleep
            err_reg <= bus.req && !ack_reg && !take;
            if (take) begin
                region_reg <= rg;
            end
            if (take && !bus.wr) begin
                unique case (rg)
                    UPAM_RG_RSVD: rdata_reg <= UNDEF_RD;
                    UPAM_RG_TXINI: rdata_reg <= UNDEF_RD; // write-only
                    UPAM_RG_TXWIN: rdata_reg <= UNDEF_RD; // write-only
                    default: rdata_reg <= page_mem[widx];
                endcase
            end else begin
                // zero between answers so a stale word never looks new
                rdata_reg <= WORD_RST;
            end
        end
    end

    // ==========================================================
    // page writes; dma registers follow the engine while it runs
    // no reset here: the ram has none, which keeps it a plain array;
    // the dma words are written last so they win over a host write
    // the host may see a dma word change between two of its reads
    always_ff @(posedge clk_i) begin
        if (take && bus.wr && writable) begin
            page_mem[widx] <= bus.wdata; // host write to any writable word, not only the tx window
        end
        if (dma_active_i) begin
            page_mem[DMA_SOF_OFS[PAGE_AW-1:1]] <= dma_sof_i;
            page_mem[DMA_CNT_OFS[PAGE_AW-1:1]] <= dma_cnt_i;
            page_mem[DMA_BYTES_OFS[PAGE_AW-1:1]] <= dma_bytes_i;
        end
    end

    // ==========================================================
    // transmit initiate: command then length fires the request
    // a length write with no command before it only updates the
    // length; the command is consumed by the start it causes
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_cmd_reg <= WORD_RST;
            tx_len_reg <= WORD_RST;
            cmd_seen_reg <= 1'b0;
            tx_start_reg <= 1'b0;
        end else begin
            tx_start_reg <= 1'b0;
            if (take && bus.wr && bus.ofs == TRANSMIT_COMMAND_REG_OFS) begin
                tx_cmd_reg <= bus.wdata;
                cmd_seen_reg <= 1'b1;
            end
            if (take && bus.wr && bus.ofs == TXLEN_OFS) begin
                tx_len_reg <= bus.wdata;
                tx_start_reg <= cmd_seen_reg;
                cmd_seen_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // outputs, each straight from a flip-flop
    // region_o reports only taken accesses, never refused ones
    assign bus.ack = ack_reg;
    assign bus.err = err_reg;
    assign bus.rdata = rdata_reg;
    assign suspended_o = suspended_reg;
    assign wake_o = wake_reg;
    assign mem_mode_o = mem_mode_reg;
    assign tx_start_o = tx_start_reg;
    assign tx_cmd_o = tx_cmd_reg;
    assign tx_len_o = tx_len_reg;
    assign region_o = region_reg;
endmodule : upam_dev

// *** hw/upam_host.sv ***
`timescale 1ns/1ns
// ==========================================================
// host end: turns user word requests into page cycles
module upam_host
    import upam_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    upam_if.host bus,
    input wire logic use_mem_i,        // path configured by driver
    input wire logic cmd_valid_i,      // user request
    output logic cmd_ready_o,          // idle, request taken
    input wire logic cmd_wr_i,
    input wire logic [11:0] cmd_ofs_i, // word-aligned offset
    input wire logic [15:0] cmd_wdata_i,
    output logic rsp_valid_o,          // one-cycle completion
    output logic [15:0] rsp_rdata_o,
    output logic rsp_err_o
);
    typedef enum logic [1:0] {
        UPAM_H_IDLE = 2'b01,
        UPAM_H_WAIT = 2'b10
    } upam_hstate_e;

    upam_hstate_e state_reg;
    logic wr_reg;
    logic mem_reg;
    logic [11:0] ofs_reg;
    logic [15:0] wdata_reg;
    logic rsp_valid_reg;
    logic [15:0] rsp_rdata_reg;
    logic rsp_err_reg;

    assign cmd_ready_o = (state_reg == UPAM_H_IDLE);

    // ==========================================================
    // request sequencer; odd bit dropped, word cycles only
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= UPAM_H_IDLE;
            wr_reg <= 1'b0;
            mem_reg <= 1'b0;
            ofs_reg <= 12'h000;
            wdata_reg <= WORD_RST;
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= WORD_RST;
            rsp_err_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= 1'b0;
            unique case (state_reg)
                UPAM_H_IDLE: begin
                    if (cmd_valid_i) begin
                        wr_reg <= cmd_wr_i;
                        mem_reg <= use_mem_i;
                        ofs_reg <= {cmd_ofs_i[11:1], 1'b0};
                        wdata_reg <= cmd_wdata_i;
                        state_reg <= UPAM_H_WAIT;
                    end
                end
                UPAM_H_WAIT: begin
                    if (bus.ack) begin
                        rsp_valid_reg <= 1'b1;
                        rsp_rdata_reg <= bus.rdata;
                        rsp_err_reg <= bus.err;
                        state_reg <= UPAM_H_IDLE;
                    end
                end
            endcase
        end
    end

    assign bus.req = (state_reg == UPAM_H_WAIT);
    assign bus.wr = wr_reg;
    assign bus.mem_path = mem_reg;
    assign bus.ofs = ofs_reg;
    assign bus.wdata = wdata_reg;
    assign rsp_valid_o = rsp_valid_reg;
    assign rsp_rdata_o = rsp_rdata_reg;
    assign rsp_err_o = rsp_err_reg;
endmodule : upam_host

// *** tb/upam_link_monitor.sv ***
`timescale 1ns/1ns
// ==========================================================
// link checker: sees only the wires between host and page
module upam_link_monitor (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic req,
    input wire logic wr,
    input wire logic mem_path,
    input wire logic [11:0] ofs,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic [15:0] rdata,
    input wire logic err
);
    // offsets whose reads never return stored data
    logic dead_rd;
    assign dead_rd = (ofs > 12'h045 && ofs < 12'h100)
        || (ofs >= 12'h140 && ofs <= 12'h14f)
        || (ofs > 12'h15d && ofs < 12'h400) || (ofs >= 12'ha00);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // ==========================================================
    // handshake timing
    a_ack_after_req:
        assert property (req && !ack |=> ack)
        else $error("request not answered on the next cycle");
    a_ack_single_pulse:
        assert property (ack |=> !ack)
        else $error("answer stood longer than one cycle");
    a_ack_has_cause:
        assert property (ack |-> $past(req))
        else $error("answer without a request");
    a_req_held_stable:
        assert property (req && !ack |=> req && $stable(ofs) && $stable(wr)
            && $stable(mem_path) && $stable(wdata))
        else $error("request changed before its answer");
    a_req_drops_after:
        assert property (ack |=> !req)
        else $error("request not released after answer");
    // ==========================================================
    // answer contents and request alignment
    a_err_with_ack:
        assert property (err |-> ack)
        else $error("refusal flagged outside an answer");
    a_rdata_idle_zero:
        assert property (!ack |-> rdata == 16'h0000)
        else $error("read data not zero between answers");
    a_odd_refused:
        assert property (req && !ack && ofs[0] |=> err)
        else $error("byte-aligned access was not refused");
    a_req_word_aligned:
        assert property (req |-> !ofs[0])
        else $error("host issued a byte-aligned cycle");
    a_dead_read_zero:
        assert property (req && !ack && !wr && dead_rd |=> rdata == 16'h0000)
        else $error("read of empty place gave data");
endmodule : upam_link_monitor

// *** tb/upam_bench.sv ***
`timescale 1ns/1ns
// ==========================================================
// both ends joined; host user side and engine side driven here
module upam_bench;
    import upam_pkg::*;
    // one bus access and the word a read should give
    typedef struct packed {
        logic wr; logic [11:0] ofs; logic [15:0] wd; logic [15:0] rd;
    } upam_row_s;
    logic clk_i;
    logic reset_n_i;
    logic use_mem_i, cmd_valid_i, cmd_wr_i, mem_mode_en_i;
    logic suspend_i, dma_active_i;
    logic [11:0] cmd_ofs_i;
    logic [15:0] cmd_wdata_i, dma_sof_i, dma_cnt_i, dma_bytes_i;
    logic cmd_ready_o, rsp_valid_o, rsp_err_o, suspended_o, wake_o;
    logic mem_mode_o, tx_start_o;
    logic [15:0] rsp_rdata_o, tx_cmd_o, tx_len_o;
    logic [6:0] region_o;
    int errors, n_checks, cycles, wakes, starts;
    logic [15:0] rd; // last read word
    logic er; // last refusal flag
    // writes then read-backs; empty places must read zero
    // the host writes bus-if words only here; dma sets 0x026 to 0x02a later
    upam_row_s rows [22] = '{
        {1'b1,12'h100,16'ha5a5,16'h0}, {1'b0,12'h100,16'h0,16'ha5a5},
        {1'b1,12'h13e,16'h1234,16'h0}, {1'b0,12'h13e,16'h0,16'h1234},
        {1'b1,12'h150,16'hbeef,16'h0}, {1'b0,12'h150,16'h0,16'hbeef},
        {1'b1,12'h15c,16'h0f0f,16'h0}, {1'b0,12'h15c,16'h0,16'h0f0f},
        {1'b1,12'h020,16'h0042,16'h0}, {1'b0,12'h020,16'h0,16'h0042},
        {1'b1,12'h044,16'h5555,16'h0}, {1'b0,12'h044,16'h0,16'h5555},
        {1'b1,12'h046,16'h7777,16'h0}, {1'b0,12'h046,16'h0,16'h0000},
        {1'b1,12'h15e,16'h3333,16'h0}, {1'b0,12'h15e,16'h0,16'h0000},
        {1'b1,12'h200,16'hffff,16'h0}, {1'b0,12'h200,16'h0,16'h0000},
        {1'b1,12'h14e,16'h4444,16'h0}, {1'b0,12'h14e,16'h0,16'h0000},
        {1'b1,12'ha00,16'h1111,16'h0}, {1'b0,12'ha00,16'h0,16'h0000}};
    upam_if bus_if ();
    upam_dev u_upam_dev (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .bus(bus_if), .mem_mode_en_i(mem_mode_en_i), .suspend_i(suspend_i),
        .suspended_o(suspended_o), .wake_o(wake_o), .mem_mode_o(mem_mode_o),
        .dma_active_i(dma_active_i), .dma_sof_i(dma_sof_i),
        .dma_cnt_i(dma_cnt_i), .dma_bytes_i(dma_bytes_i),
        .tx_start_o(tx_start_o), .tx_cmd_o(tx_cmd_o), .tx_len_o(tx_len_o),
        .region_o(region_o));
    upam_host u_upam_host (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .bus(bus_if), .use_mem_i(use_mem_i), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .cmd_wr_i(cmd_wr_i),
        .cmd_ofs_i(cmd_ofs_i), .cmd_wdata_i(cmd_wdata_i),
        .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
        .rsp_err_o(rsp_err_o));
    upam_link_monitor u_upam_link_monitor (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .req(bus_if.req), .wr(bus_if.wr),
        .mem_path(bus_if.mem_path), .ofs(bus_if.ofs), .wdata(bus_if.wdata),
        .ack(bus_if.ack), .rdata(bus_if.rdata), .err(bus_if.err));
    // ==========================================================
    // clock, pulse counters and hang guard
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (wake_o === 1'b1) wakes++;
        if (tx_start_o === 1'b1) starts++;
        if (cycles == 5000) begin // far beyond the run's real length
            errors++;
            summarize();
        end
    end
    task automatic check(input string name, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            errors++;
        end
    endtask : check
    // one user command; waits for idle, then a bounded wait for the answer
    task automatic access(input logic w, input logic [11:0] o,
            input logic [15:0] d);
        int i;
        while (cmd_ready_o !== 1'b1) begin
            @(posedge clk_i);
            #1;
        end
        cmd_valid_i = 1'b1;
        cmd_wr_i = w;
        cmd_ofs_i = o;
        cmd_wdata_i = d;
        @(posedge clk_i);
        #1;
        cmd_valid_i = 1'b0;
        for (i = 0; i < 20 && rsp_valid_o !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        check("rsp_valid", rsp_valid_o, 16'h1);
        rd = rsp_rdata_o;
        er = rsp_err_o;
    endtask : access
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // ==========================================================
    // main sequence
    initial begin
        {use_mem_i, cmd_valid_i, cmd_wr_i, mem_mode_en_i} = 4'h0;
        {suspend_i, dma_active_i, cmd_ofs_i, cmd_wdata_i} = 30'h0;
        {dma_sof_i, dma_cnt_i, dma_bytes_i} = 48'h0;
        reset_n_i = 1'b0;
        repeat (10) @(posedge clk_i);
        #1;
        check("ready_rst", cmd_ready_o, 16'h1);
        check("mem_rst", mem_mode_o, 16'h0);
        check("region_rst", region_o, UPAM_RG_RSVD);
        reset_n_i = 1'b1;
        for (int k = 0; k < 22; k++) begin
            access(rows[k].wr, rows[k].ofs, rows[k].wd);
            check("rdata", rd, rows[k].rd);
            check("err", er, 16'h0);
        end
        // memory path refused until the engine enables it
        use_mem_i = 1'b1;
        access(1'b0, 12'h100, 16'h0);
        check("mem_refused", er, 16'h1);
        mem_mode_en_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        check("mem_mode", mem_mode_o, 16'h1);
        access(1'b0, 12'h100, 16'h0);
        check("mem_rd", rd, 16'ha5a5);
        check("mem_err", er, 16'h0);
        use_mem_i = 1'b0;
        // dma words follow the engine while a transfer runs
        {dma_sof_i, dma_cnt_i, dma_bytes_i} = 48'h1357_0246_0abc;
        dma_active_i = 1'b1;
        access(1'b0, 12'h026, 16'h0);
        check("dma_sof", rd, 16'h1357);
        dma_sof_i = 16'h2468;
        access(1'b0, 12'h026, 16'h0);
        check("dma_sof2", rd, 16'h2468);
        access(1'b0, 12'h028, 16'h0);
        check("dma_cnt", rd, 16'h0246);
        access(1'b0, 12'h02a, 16'h0);
        check("dma_bytes", rd, 16'h0abc);
        dma_active_i = 1'b0;
        // command then length starts; length alone must not
        starts = 0;
        access(1'b1, 12'h144, 16'h00c0);
        access(1'b1, 12'h146, 16'h0040);
        repeat (2) @(posedge clk_i);
        #1;
        check("tx_start", 16'(starts), 16'h1);
        check("tx_cmd", tx_cmd_o, 16'h00c0);
        check("tx_len", tx_len_o, 16'h0040);
        check("region", region_o, UPAM_RG_TXINI);
        access(1'b1, 12'h146, 16'h0080);
        repeat (2) @(posedge clk_i);
        #1;
        check("tx_lone", 16'(starts), 16'h1);
        check("tx_len2", tx_len_o, 16'h0080);
        // suspend: reads refused, an i/o write wakes but is dropped
        suspend_i = 1'b1;
        @(posedge clk_i);
        #1;
        suspend_i = 1'b0;
        @(posedge clk_i);
        #1;
        check("suspended", suspended_o, 16'h1);
        wakes = 0;
        access(1'b0, 12'h100, 16'h0);
        check("susp_rd", er, 16'h1);
        access(1'b1, 12'h100, 16'h0000);
        check("wake_wr", er, 16'h1);
        repeat (2) @(posedge clk_i);
        #1;
        check("wakes", 16'(wakes), 16'h1);
        check("awake", suspended_o, 16'h0);
        access(1'b0, 12'h100, 16'h0);
        check("kept", rd, 16'ha5a5);
        // an odd user offset must still go out as a word cycle
        access(1'b0, 12'h101, 16'h0);
        check("odd_rd", rd, 16'ha5a5);
        check("odd_err", er, 16'h0);
        summarize();
    end
endmodule : upam_bench
